// ==== dv/apms_checker.sv ====
// Port assertions for the protection and mute sequencer
`timescale 1ns/1ps
module apms_checker import apms_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic address_select_input,
	input wire logic standby_control_input,
	input wire logic standby_mute_level_input,
	input wire logic supply_reset_input,
	input wire apms_sense_t [3:0] sense,
	input wire logic diagnostic_output_oe,
	input wire logic standby_clip_output_oe,
	input wire logic amp_on,
	input wire logic [3:0] channel_enable,
	input wire logic [1:0] pair_ramping,
	input wire logic fast_mute
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Shut-down span is far past any delay range, so it is counted
	logic [11:0] shut_cnt;
	wire logic stb_off = amp_on && !standby_control_input
		&& !(address_select_input && standby_mute_level_input);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shut_cnt <= 12'h000;
		end else if (stb_off && shut_cnt != 12'hfff) begin
			shut_cnt <= shut_cnt + 12'h001;
		end else if (!stb_off) begin
			shut_cnt <= 12'h000;
		end
	end
	sequence s_start_write;
		psel && penable && pready && pwrite && paddr == INSTR1_OFS && pwdata[START_BIT];
	endsequence
	sequence s_shut_begin;
		$fell(standby_control_input) && amp_on && !address_select_input;
	endsequence
	a_short_trips_chan: assert property ($rose(sense[0].short_gnd) && channel_enable[0]
		|-> ##[1:2] !channel_enable[0]) else $error("short left channel on");
	a_retry_hold_off: assert property ($fell(channel_enable[0]) && amp_on
		|=> !channel_enable[0] [*8]) else $error("channel back too soon");
	a_safe_operating_area_guard_qualifies: assert property ($rose(sense[0].safe_operating_area_guard_lo)
		&& sense[0][5:0] == 6'h04 && channel_enable[0] |=> channel_enable[0] [*8])
		else $error("low voltage trip not qualified");
	a_por_diagnostic_output_low: assert property ($rose(standby_control_input)
		&& !address_select_input && !amp_on |-> ##[1:2] diagnostic_output_oe)
		else $error("no diagnostic low on standby rise");
	a_start_runs: assert property (s_start_write ##0 (standby_control_input && !amp_on
		&& !address_select_input && !supply_reset_input) |-> ##[1:2] amp_on)
		else $error("start write did not start");
	a_stb_fall_fast: assert property (s_shut_begin |-> ##[1:3] fast_mute)
		else $error("no fast mute on standby fall");
	a_shut_bounded: assert property (shut_cnt <= 12'h7da)
		else $error("shut-down took too long");
	a_supply_off: assert property (supply_reset_input && !address_select_input
		|-> ##[1:2] (!amp_on && diagnostic_output_oe)) else $error("supply drop ignored");
	a_legacy_no_stbclip: assert property (address_select_input
		&& $past(address_select_input) |-> !standby_clip_output_oe)
		else $error("standby pin driven in legacy");
	a_legacy_starts: assert property (address_select_input && $rose(standby_control_input)
		&& !amp_on && !supply_reset_input |-> ##[1:3] amp_on) else $error("legacy no start");
	a_soft_ramp_spans: assert property ($rose(pair_ramping[0])
		|-> pair_ramping[0] [*8]) else $error("soft ramp too short");
endmodule : apms_checker

bind apms_top apms_checker chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.pready, .address_select_input, .standby_control_input, .standby_mute_level_input,
	.supply_reset_input, .sense, .diagnostic_output_oe, .standby_clip_output_oe, .amp_on,
	.channel_enable, .pair_ramping, .fast_mute);

// ==== dv/apms_host.sv ====
// Register bus master standing in for the controlling processor
`timescale 1ns/1ps
module apms_host (
	input wire logic pclk,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end
	// Start and disable commands travel as writes
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// No wait count assumed; the bench watchdog ends a hang
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
endmodule : apms_host

// ==== dv/apms_top_tb.sv ====
// Self-checking bench for the protection and mute sequencer
`timescale 1ns/1ps
module apms_top_tb;
	import apms_pkg::*;
	localparam int RETRY = 40;
	localparam int QUAL = 20;
	localparam int SOFT = 30;
	localparam int SLOW = 50;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel, penable, pwrite, pready, pslverr, diagnostic_output, diagnostic_output_oe;
	logic standby_clip_output, standby_clip_output_oe, amp_on, fast_mute, slow_ramp;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0] channel_enable;
	logic [1:0] pair_muted, pair_ramping;
	logic address_select_input = 1'b0;
	logic standby_control_input = 1'b0;
	logic standby_mute_level_input = 1'b0;
	logic supply_reset_input = 1'b0;
	logic low_battery_input = 1'b0;
	logic high_battery_input = 1'b0;
	logic temp_warning_input = 1'b0;
	apms_sense_t [3:0] sense = '0;
	int failures = 0;
	int samples_checked = 0;
	always #25 pclk = ~pclk;
	apms_top #(.RETRY_CYC(23'(RETRY)), .SAFE_OPERATING_AREA_GUARD_QUAL_CYC(23'(QUAL)), .SOFT_CYC(23'(SOFT)),
		.RAMP_CYC(23'(25)), .RAMP_SLOW_CYC(23'(SLOW))) DUT (.pclk, .presetn, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .address_select_input,
		.standby_control_input, .standby_mute_level_input, .supply_reset_input,
		.low_battery_input, .high_battery_input, .temp_warning_input, .sense,
		.diagnostic_output, .diagnostic_output_oe, .standby_clip_output, .standby_clip_output_oe,
		.amp_on, .channel_enable, .pair_muted, .pair_ramping, .fast_mute, .slow_ramp);
	apms_host host (.pclk, .prdata, .pready, .pslverr, .psel, .penable, .pwrite, .paddr, .pwdata);
	function automatic logic [31:0] exp_status(input logic [2:0] st, input logic por);
		return {24'h0, por, st, 4'h0};
	endfunction : exp_status
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_reg
	task automatic chk_pin(input logic [3:0] got, input logic [3:0] exp);
		chk_reg({28'h0, got}, {28'h0, exp});
	endtask : chk_pin
	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask : tick
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		host.xfer(1'b1, a, d, q, e);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		logic e;
		host.xfer(1'b0, a, 32'h0, q, e);
		chk_reg(q, exp);
	endtask : rd
	task automatic results;
		$display("failures=%0d samples_checked=%0d", failures, samples_checked);
		if (failures == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : results
	initial begin
		#(50 * 60000);
		failures++;
		results();
	end
	initial begin
		logic [31:0] q;
		logic e;
		logic [5:0] fb [4];
		int ch, lvl, n;
		fb = '{6'h20, 6'h10, 6'h08, 6'h02};
		void'($urandom(11));
		lvl = $urandom % 3;
		ch = $urandom % 4;
		tick(16);
		presetn <= 1'b1;
		rd(INSTR3_OFS, {20'h0, INSTR3_RST});
		host.xfer(1'b0, 8'h40, 32'h0, q, e);
		chk_reg({q[30:0], e}, 32'h1);
		@(posedge pclk) standby_control_input <= 1'b1;
		tick(3);
		chk_pin({3'h0, diagnostic_output_oe}, 4'h1);
		rd(STATUS_OFS, exp_status(3'h1, 1'b1));
		wr(INSTR2_OFS, 32'(lvl) << CLIPLVL_LSB);
		wr(INSTR1_OFS, 32'h1);
		tick(3);
		chk_pin({amp_on, slow_ramp, diagnostic_output_oe, 1'b0}, 4'hc);
		tick(SLOW);
		rd(STATUS_OFS, exp_status(3'h3, 1'b0));
		tick(SOFT + 5);
		chk_pin({2'h0, pair_muted}, 4'h0);
		wr(INSTR2_OFS, (32'(lvl) << CLIPLVL_LSB) | 32'h1);
		tick(5);
		chk_pin({pair_ramping, pair_muted}, 4'h4);
		tick(SOFT);
		chk_pin({2'h0, pair_muted}, 4'h1);
		wr(INSTR2_OFS, (32'(lvl) << CLIPLVL_LSB) | 32'h4);
		tick(FAST_CYC + 5);
		chk_pin({2'h0, pair_muted}, 4'h3);
		wr(INSTR2_OFS, 32'(lvl) << CLIPLVL_LSB);
		tick(5);
		chk_pin({2'h0, pair_muted}, 4'h3);
		tick(SOFT);
		chk_pin({2'h0, pair_muted}, 4'h0);
		@(posedge pclk) high_battery_input <= 1'b1;
		tick(3);
		chk_pin({3'h0, diagnostic_output_oe}, 4'h1);
		@(posedge pclk) {low_battery_input, high_battery_input} <= 2'b10;
		tick(3);
		chk_pin({3'h0, diagnostic_output_oe}, 4'h1);
		@(posedge pclk) low_battery_input <= 1'b0;
		tick(3);
		chk_pin({3'h0, diagnostic_output_oe}, 4'h0);
		for (int k = 0; k < 4; k++) begin
			@(posedge pclk) sense[k] <= apms_sense_t'({3'h0, fb[k]});
			tick(4);
			chk_pin(channel_enable, 4'hf & ~(4'h1 << k));
			chk_pin({3'h0, diagnostic_output_oe}, 4'h1);
			rd(CHSTAT_OFS + 8'(4 * k), 32'h40 | (32'h2 << k));
			@(posedge pclk) sense[k] <= '0;
			tick(RETRY + 5);
			chk_pin(channel_enable, 4'hf);
		end
		@(posedge pclk) sense[ch].short_load <= 1'b1;
		n = 0;
		repeat (2 * RETRY + 20) begin
			@(posedge pclk);
			n += (channel_enable[ch] !== 1'b0);
		end
		chk_pin({3'h0, n != 0 && n < 20}, 4'h1);
		wr(INSTR3_OFS, 32'h0f0 | (32'h100 << ch));
		n = 0;
		repeat (2 * RETRY + 20) begin
			@(posedge pclk);
			n += (channel_enable[ch] !== 1'b0);
		end
		chk_pin(4'(n), 4'h0);
		@(posedge pclk) sense[ch].short_load <= 1'b0;
		wr(INSTR3_OFS, 32'h0f0);
		tick(RETRY + 5);
		@(posedge pclk) sense[0].safe_operating_area_guard_lo <= 1'b1;
		tick(QUAL - 5);
		chk_pin(channel_enable, 4'hf);
		tick(10);
		chk_pin(channel_enable, 4'he);
		@(posedge pclk) sense[0].safe_operating_area_guard_lo <= 1'b0;
		tick(RETRY + 5);
		@(posedge pclk) sense[1].spk_miss <= 1'b1;
		tick(SPK_QUAL_CYC - 5);
		chk_pin(channel_enable, 4'hf);
		tick(10);
		chk_pin(channel_enable, 4'hd);
		rd(CHSTAT_OFS + 8'h04, 32'h60);
		@(posedge pclk) sense[1].spk_miss <= 1'b0;
		tick(RETRY + 5);
		wr(INSTR2_OFS, (32'(lvl) << CLIPLVL_LSB) | 32'h30);
		wr(INSTR3_OFS, 32'h0f0 | (32'h1 << ch));
		@(posedge pclk) sense[ch].clip_lvl <= (3'h1 << lvl) >> 1;
		tick(4);
		rd(CHSTAT_OFS + 8'(4 * ch), 32'h0);
		@(posedge pclk) begin
			sense[ch].clip_lvl <= 3'h1 << lvl;
			sense[ch ^ 1].short_gnd <= 1'b1;
			temp_warning_input <= 1'b1;
		end
		tick(4);
		chk_pin({standby_clip_output_oe, diagnostic_output_oe, 2'h0}, 4'h8);
		chk_pin({2'h0, standby_clip_output, diagnostic_output}, 4'h0);
		rd(CHSTAT_OFS + 8'(4 * ch), 32'h1);
		rd(CHSTAT_OFS + 8'(4 * (ch ^ 1)), 32'h42);
		rd(STATUS_OFS, exp_status(3'h3, 1'b0) | 32'h1);
		@(posedge pclk) begin
			sense <= '0;
			temp_warning_input <= 1'b0;
			standby_control_input <= 1'b0;
		end
		tick(4);
		chk_pin({amp_on, fast_mute, 2'h0}, 4'hc);
		tick(FAST_CYC + 10);
		chk_pin({3'h0, amp_on}, 4'h0);
		@(posedge pclk) standby_control_input <= 1'b1;
		tick(3);
		chk_pin({3'h0, diagnostic_output_oe}, 4'h1);
		wr(INSTR2_OFS, 32'h8);
		wr(INSTR1_OFS, 32'h1);
		tick(3);
		chk_pin({amp_on, slow_ramp, 2'h0}, 4'h8);
		tick(SLOW + 2);
		wr(INSTR2_OFS, 32'h5);
		@(posedge pclk) supply_reset_input <= 1'b1;
		tick(3);
		chk_pin({amp_on, diagnostic_output_oe, 2'h0}, 4'h4);
		@(posedge pclk) supply_reset_input <= 1'b0;
		rd(INSTR2_OFS, 32'h0);
		rd(STATUS_OFS, exp_status(3'h1, 1'b1));
		@(posedge pclk) standby_control_input <= 1'b0;
		tick(3);
		@(posedge pclk) address_select_input <= 1'b1;
		@(posedge pclk) standby_control_input <= 1'b1;
		tick(3);
		chk_pin({3'h0, amp_on}, 4'h1);
		tick(SLOW + SOFT + 5);
		chk_pin({2'h0, pair_muted}, 4'h0);
		wr(INSTR2_OFS, 32'h4);
		rd(INSTR2_OFS, 32'h0);
		host.xfer(1'b0, STATUS_OFS, 32'h0, q, e);
		chk_reg(q & 32'h88, 32'h08);
		@(posedge pclk) begin
			standby_control_input <= 1'b0;
			standby_mute_level_input <= 1'b1;
		end
		tick(5);
		chk_pin({2'h0, pair_muted}, 4'h0);
		tick(SOFT);
		chk_pin({2'h0, pair_muted}, 4'h3);
		@(posedge pclk) begin
			standby_control_input <= 1'b1;
			standby_mute_level_input <= 1'b0;
		end
		tick(SOFT + 5);
		@(posedge pclk) standby_control_input <= 1'b0;
		tick(4);
		chk_pin({amp_on, fast_mute, 2'h0}, 4'hc);
		tick(FAST_CYC + 10);
		chk_pin({3'h0, amp_on}, 4'h0);
		results();
	end
endmodule : apms_top_tb

// ==== rtl/apms_chan.sv ====
// Per-channel short, safe-operating-area and speaker protection with timed retry
`timescale 1ns/1ps
module apms_chan import apms_pkg::*; #(
	parameter logic [CNT_W-1:0] RETRY_CYC = RETRY_CYC_DEF,
	parameter logic [CNT_W-1:0] SAFE_OPERATING_AREA_GUARD_QUAL_CYC = SAFE_OPERATING_AREA_GUARD_QUAL_CYC_DEF
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire apms_sense_t sense,
	input wire logic [1:0] clip_sel,
	input wire logic run,
	input wire logic perm_off,
	output apms_stat_t stat
);
	logic [CNT_W-1:0] safe_operating_area_guard_cnt_reg;
	logic [CNT_W-1:0] spk_cnt_reg;
	logic [CNT_W-1:0] retry_cnt_reg;
	logic safe_operating_area_guard_q;
	logic spk_q;
	logic shorted;
	logic trip;
	logic clip_now;

	assign safe_operating_area_guard_q = sense.safe_operating_area_guard_lo && safe_operating_area_guard_cnt_reg == SAFE_OPERATING_AREA_GUARD_QUAL_CYC - CNT_W'(1);
	assign spk_q = sense.spk_miss && spk_cnt_reg == SPK_QUAL_CYC - CNT_W'(1);
	assign shorted = sense.short_gnd | sense.short_vp | sense.short_load;
	assign trip = run && !stat.off && !perm_off && (shorted || sense.safe_operating_area_guard_hi || safe_operating_area_guard_q || spk_q);
	assign clip_now = clip_sel == CLIP_10PCT ? sense.clip_lvl[2] :
		clip_sel == CLIP_5PCT ? sense.clip_lvl[1] : sense.clip_lvl[0];

	// Qualification counters only run while the sequencer runs and the channel is not tripped off, even when its disable bit holds it off
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			safe_operating_area_guard_cnt_reg <= '0;
			spk_cnt_reg <= '0;
		end else begin
			safe_operating_area_guard_cnt_reg <= (run && !stat.off && sense.safe_operating_area_guard_lo && !safe_operating_area_guard_q) ?
				safe_operating_area_guard_cnt_reg + CNT_W'(1) : '0;
			spk_cnt_reg <= (run && !stat.off && sense.spk_miss && !spk_q) ?
				spk_cnt_reg + CNT_W'(1) : '0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat <= '0;
			retry_cnt_reg <= '0;
		end else begin
			stat.clip <= run && !stat.off && clip_now;
			stat.dis <= perm_off;
			if (!run) begin
				stat.off <= 1'b0;
				{stat.spk_fault, stat.safe_operating_area_guard_trip} <= 2'b00;
				{stat.short_load, stat.short_vp, stat.short_gnd} <= 3'b000;
				retry_cnt_reg <= '0;
			end else if (trip) begin
				stat.off <= 1'b1;
				stat.short_gnd <= sense.short_gnd;
				stat.short_vp <= sense.short_vp;
				stat.short_load <= sense.short_load;
				stat.safe_operating_area_guard_trip <= sense.safe_operating_area_guard_hi | safe_operating_area_guard_q;
				stat.spk_fault <= spk_q;
				retry_cnt_reg <= RETRY_CYC - CNT_W'(1);
			end else if (stat.off && retry_cnt_reg != '0) begin
				retry_cnt_reg <= retry_cnt_reg - CNT_W'(1);
			end else if (stat.off && !perm_off) begin
				// Back on; flags stand a cycle longer so a lasting short or high guard fault keeps the pin low
				stat.off <= 1'b0;
			end else if (!stat.off) begin
				{stat.spk_fault, stat.safe_operating_area_guard_trip} <= 2'b00;
				{stat.short_load, stat.short_vp, stat.short_gnd} <= 3'b000;
			end
		end
	end
endmodule : apms_chan

// ==== rtl/apms_pkg.sv ====
// Constants, register map and carrier types of the amplifier protection and mute sequencer
package apms_pkg;
	localparam int CNT_W = 23;
	localparam int CLK_HZ = 20_000_000;
	localparam int CYC_PER_US = CLK_HZ / 1_000_000;
	localparam int CYC_PER_MS = CLK_HZ / 1_000;

	// Times in their own units
	localparam int RETRY_MS = 16;
	localparam int SAFE_OPERATING_AREA_GUARD_QUAL_US = 300;
	localparam int SPK_QUAL_US = 80;
	localparam int SOFT_MUTE_MS = 20;
	localparam int FAST_MUTE_US = 100;
	localparam int RAMP_MS = 50;
	localparam int RAMP_SLOW_MS = 150;

	// Derived cycle counts
	localparam logic [CNT_W-1:0] RETRY_CYC_DEF = CNT_W'(RETRY_MS * CYC_PER_MS);
	localparam logic [CNT_W-1:0] SAFE_OPERATING_AREA_GUARD_QUAL_CYC_DEF = CNT_W'(SAFE_OPERATING_AREA_GUARD_QUAL_US * CYC_PER_US);
	localparam logic [CNT_W-1:0] SPK_QUAL_CYC = CNT_W'(SPK_QUAL_US * CYC_PER_US);
	localparam logic [CNT_W-1:0] SOFT_CYC_DEF = CNT_W'(SOFT_MUTE_MS * CYC_PER_MS);
	localparam logic [CNT_W-1:0] FAST_CYC = CNT_W'(FAST_MUTE_US * CYC_PER_US);
	localparam logic [CNT_W-1:0] RAMP_CYC_DEF = CNT_W'(RAMP_MS * CYC_PER_MS);
	localparam logic [CNT_W-1:0] RAMP_SLOW_CYC_DEF = CNT_W'(RAMP_SLOW_MS * CYC_PER_MS);

	// Register byte offsets
	localparam logic [7:0] INSTR1_OFS = 8'h00;
	localparam logic [7:0] INSTR2_OFS = 8'h04;
	localparam logic [7:0] INSTR3_OFS = 8'h08;
	localparam logic [7:0] STATUS_OFS = 8'h0c;
	localparam logic [7:0] CHSTAT_OFS = 8'h10;

	// Field positions
	localparam int START_BIT = 0;
	localparam int MUTE_LSB = 0;
	localparam int FAST_BIT = 2;
	localparam int LOWPOP_BIT = 3;
	localparam int LOADREP_BIT = 4;
	localparam int TEMPREP_BIT = 5;
	localparam int CLIPLVL_LSB = 6;
	localparam int TOSTB_LSB = 0;
	localparam int CLIPEN_LSB = 4;
	localparam int CHDIS_LSB = 8;
	localparam int POR_BIT = 7;

	// Reset values
	localparam logic [7:0] INSTR1_RST = 8'h00;
	localparam logic [7:0] INSTR2_RST = 8'h00;
	localparam logic [11:0] INSTR3_RST = 12'h0f0;

	// Clip level selection
	localparam logic [1:0] CLIP_2PCT = 2'h0;
	localparam logic [1:0] CLIP_5PCT = 2'h1;
	localparam logic [1:0] CLIP_10PCT = 2'h2;

	// Comparator outputs of one channel
	typedef struct packed {
		logic [2:0] clip_lvl;
		logic short_gnd;
		logic short_vp;
		logic short_load;
		logic safe_operating_area_guard_lo;
		logic safe_operating_area_guard_hi;
		logic spk_miss;
	} apms_sense_t;

	// Readable state of one channel
	typedef struct packed {
		logic dis;
		logic off;
		logic spk_fault;
		logic safe_operating_area_guard_trip;
		logic short_load;
		logic short_vp;
		logic short_gnd;
		logic clip;
	} apms_stat_t;
endpackage : apms_pkg

// ==== rtl/apms_timer.sv ====
// One-shot down counter used for mute and start-up ramps
`timescale 1ns/1ps
module apms_timer import apms_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic start,
	input wire logic [CNT_W-1:0] len,
	output logic busy,
	output logic done
);
	logic [CNT_W-1:0] cnt_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg <= '0;
			busy <= 1'b0;
			done <= 1'b0;
		end else if (start) begin
			// A restart drops the old run, so the newest request sets the pace
			cnt_reg <= len - CNT_W'(1);
			busy <= 1'b1;
			done <= 1'b0;
		end else if (busy && cnt_reg == '0) begin
			busy <= 1'b0;
			done <= 1'b1;
		end else begin
			cnt_reg <= busy ? cnt_reg - CNT_W'(1) : cnt_reg;
			done <= 1'b0;
		end
	end
endmodule : apms_timer

// ==== rtl/apms_top.sv ====
// Amplifier mode, standby, start-up, mute and protection sequencer with APB registers
`timescale 1ns/1ps
module apms_top import apms_pkg::*; #(
	parameter logic [CNT_W-1:0] RETRY_CYC = RETRY_CYC_DEF,
	parameter logic [CNT_W-1:0] SAFE_OPERATING_AREA_GUARD_QUAL_CYC = SAFE_OPERATING_AREA_GUARD_QUAL_CYC_DEF,
	parameter logic [CNT_W-1:0] SOFT_CYC = SOFT_CYC_DEF,
	parameter logic [CNT_W-1:0] RAMP_CYC = RAMP_CYC_DEF,
	parameter logic [CNT_W-1:0] RAMP_SLOW_CYC = RAMP_SLOW_CYC_DEF
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic address_select_input,
	input wire logic standby_control_input,
	input wire logic standby_mute_level_input,
	input wire logic supply_reset_input,
	input wire logic low_battery_input,
	input wire logic high_battery_input,
	input wire logic temp_warning_input,
	input wire apms_sense_t [3:0] sense,
	output logic diagnostic_output,
	output logic diagnostic_output_oe,
	output logic standby_clip_output,
	output logic standby_clip_output_oe,
	output logic amp_on,
	output logic [3:0] channel_enable,
	output logic [1:0] pair_muted,
	output logic [1:0] pair_ramping,
	output logic fast_mute,
	output logic slow_ramp
);
	typedef enum logic [2:0] {ST_OFF, ST_POR_WAIT, ST_RAMP, ST_RUN, ST_SHUT} apms_state_t;

	apms_state_t state_reg;
	logic [7:0] instr1_reg;
	logic [7:0] instr2_reg;
	logic [11:0] instr3_reg;
	logic por_flag_reg;
	logic stb_prev_reg;
	logic [1:0] mute_target_reg;
	apms_stat_t [3:0] ch_stat;

	logic legacy;
	logic wr_en;
	logic setup;
	logic start_pulse;
	logic stb_rise;
	logic stb_active;
	logic go_ramp;
	logic go_shut;
	logic run;
	logic seq_done;
	logic [CNT_W-1:0] seq_len;
	logic [1:0] mute_req;
	logic [1:0] pair_start;
	logic [1:0] pair_done;
	logic [1:0] pair_busy;
	logic fast_req;
	logic [1:0] clip_sel;
	logic [3:0] to_stb;
	logic [3:0] clip_en;
	logic [3:0] clip_v;
	logic load_fault;
	logic temp_rep;
	logic load_rep;
	logic diagnostic_output_low;
	logic stb_clip_low;
	logic [31:0] rdata_next;
	logic addr_ok;

	// Legacy mode ignores every latch and runs on fixed settings
	assign legacy = address_select_input;
	assign setup = psel && !penable;
	assign wr_en = psel && penable && pready && pwrite;
	assign start_pulse = !legacy && wr_en && paddr == INSTR1_OFS && pwdata[START_BIT];
	assign stb_active = legacy ? (standby_control_input | standby_mute_level_input) :
		standby_control_input;
	assign stb_rise = !legacy && standby_control_input && !stb_prev_reg;

	assign go_ramp = !supply_reset_input && ((state_reg == ST_OFF && legacy && stb_active) ||
		(state_reg == ST_POR_WAIT && start_pulse && stb_active));
	assign go_shut = !supply_reset_input && !stb_active &&
		(state_reg == ST_RAMP || state_reg == ST_RUN);
	assign run = state_reg == ST_RAMP || state_reg == ST_RUN || state_reg == ST_SHUT;
	assign seq_len = go_shut ? FAST_CYC :
		(!legacy && !instr2_reg[LOWPOP_BIT]) ? RAMP_SLOW_CYC : RAMP_CYC;

	// Sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ST_OFF;
		end else if (supply_reset_input) begin
			state_reg <= ST_OFF;
		end else begin
			unique case (state_reg)
				ST_OFF: begin
					// Standby high in bus mode waits for a start write, after a supply drop too
					if (!legacy && stb_active) begin
						state_reg <= ST_POR_WAIT;
					end else if (go_ramp) begin
						state_reg <= ST_RAMP;
					end
				end
				ST_POR_WAIT: begin
					if (!stb_active) begin
						state_reg <= ST_OFF;
					end else if (go_ramp) begin
						state_reg <= ST_RAMP;
					end
				end
				ST_RAMP: begin
					if (go_shut) begin
						state_reg <= ST_SHUT;
					end else if (seq_done) begin
						state_reg <= ST_RUN;
					end
				end
				ST_RUN: begin
					if (go_shut) begin
						state_reg <= ST_SHUT;
					end
				end
				ST_SHUT: begin
					if (seq_done) begin
						state_reg <= ST_OFF;
					end
				end
			endcase
		end
	end

	apms_timer u_seq_timer (
		.pclk(pclk),
		.presetn(presetn),
		.start(go_ramp || go_shut),
		.len(seq_len),
		.busy(),
		.done(seq_done)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stb_prev_reg <= 1'b0;
		end else begin
			stb_prev_reg <= standby_control_input;
		end
	end

	// Mute request per pair: bit 0 front, bit 1 rear
	assign fast_req = state_reg == ST_SHUT || (!legacy && instr2_reg[FAST_BIT]);
	always_comb begin
		for (int p = 0; p < 2; p++) begin
			if (state_reg != ST_RUN) begin
				mute_req[p] = 1'b1;
			end else if (legacy) begin
				mute_req[p] = !standby_control_input;
			end else begin
				mute_req[p] = fast_req | instr2_reg[MUTE_LSB + p];
			end
			pair_start[p] = (mute_req[p] | fast_req) != mute_target_reg[p];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mute_target_reg <= 2'h3;
		end else begin
			mute_target_reg <= mute_req | {2{fast_req}};
		end
	end

	// Fast mute uses the short ramp; every release and soft mute the long one
	for (genvar p = 0; p < 2; p++) begin : g_pair
		apms_timer u_pair_timer (
			.pclk(pclk),
			.presetn(presetn),
			.start(pair_start[p]),
			.len((fast_req && !mute_target_reg[p]) ? FAST_CYC : SOFT_CYC),
			.busy(pair_busy[p]),
			.done(pair_done[p])
		);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pair_muted <= 2'h3;
			pair_ramping <= 2'h0;
			fast_mute <= 1'b0;
		end else begin
			for (int p = 0; p < 2; p++) begin
				if (pair_done[p]) begin
					pair_muted[p] <= mute_target_reg[p];
				end
			end
			pair_ramping <= pair_busy;
			fast_mute <= fast_req;
		end
	end

	// Control latches; a supply drop in bus mode returns them all to their reset values
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			instr1_reg <= INSTR1_RST;
			instr2_reg <= INSTR2_RST;
			instr3_reg <= INSTR3_RST;
		end else if (!legacy && (supply_reset_input || stb_rise)) begin
			instr1_reg <= INSTR1_RST;
			instr2_reg <= INSTR2_RST;
			instr3_reg <= INSTR3_RST;
		end else if (wr_en && !legacy) begin
			if (paddr == INSTR1_OFS) begin
				instr1_reg <= pwdata[7:0];
			end
			if (paddr == INSTR2_OFS) begin
				instr2_reg <= pwdata[7:0];
			end
			if (paddr == INSTR3_OFS) begin
				instr3_reg <= pwdata[11:0];
			end
		end
	end

	// Setting wins over the clearing start write in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			por_flag_reg <= 1'b1;
		end else if (!legacy && (supply_reset_input || stb_rise)) begin
			por_flag_reg <= 1'b1;
		end else if (start_pulse || legacy) begin
			por_flag_reg <= 1'b0;
		end
	end

	// Channels
	assign clip_sel = legacy ? CLIP_2PCT : instr2_reg[CLIPLVL_LSB +: 2];
	for (genvar c = 0; c < 4; c++) begin : g_chan
		apms_chan #(
			.RETRY_CYC(RETRY_CYC),
			.SAFE_OPERATING_AREA_GUARD_QUAL_CYC(SAFE_OPERATING_AREA_GUARD_QUAL_CYC)
		) u_chan (
			.pclk(pclk),
			.presetn(presetn),
			.sense(sense[c]),
			.clip_sel(clip_sel),
			.run(run),
			.perm_off(!legacy && instr3_reg[CHDIS_LSB + c]),
			.stat(ch_stat[c])
		);
		assign clip_v[c] = ch_stat[c].clip;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			amp_on <= 1'b0;
			channel_enable <= 4'h0;
			slow_ramp <= 1'b0;
		end else begin
			amp_on <= run;
			slow_ramp <= state_reg == ST_RAMP && !legacy && !instr2_reg[LOWPOP_BIT];
			for (int c = 0; c < 4; c++) begin
				channel_enable[c] <= run && !ch_stat[c].off && !ch_stat[c].dis;
			end
		end
	end

	// Diagnostic and standby pin pull-downs
	assign to_stb = legacy ? 4'h0 : instr3_reg[TOSTB_LSB +: 4];
	assign clip_en = legacy ? 4'hf : instr3_reg[CLIPEN_LSB +: 4];
	always_comb begin
		load_fault = 1'b0;
		for (int c = 0; c < 4; c++) begin
			load_fault = load_fault | ch_stat[c].short_gnd | ch_stat[c].short_vp |
				ch_stat[c].short_load | ch_stat[c].safe_operating_area_guard_trip | ch_stat[c].spk_fault;
		end
	end
	assign load_rep = legacy || !instr2_reg[LOADREP_BIT];
	assign temp_rep = legacy || !instr2_reg[TEMPREP_BIT];
	assign diagnostic_output_low = (por_flag_reg && !legacy) || low_battery_input || high_battery_input ||
		(temp_warning_input && temp_rep) || (load_fault && load_rep) ||
		|(clip_v & clip_en & ~to_stb);
	assign stb_clip_low = |(clip_v & clip_en & to_stb);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			diagnostic_output <= 1'b0;
			diagnostic_output_oe <= 1'b0;
			standby_clip_output <= 1'b0;
			standby_clip_output_oe <= 1'b0;
		end else begin
			diagnostic_output <= 1'b0;
			diagnostic_output_oe <= diagnostic_output_low;
			standby_clip_output <= 1'b0;
			standby_clip_output_oe <= stb_clip_low && !legacy;
		end
	end

	// APB read mux; status stays readable whatever the pin reporting does
	always_comb begin
		rdata_next = 32'h0000_0000;
		addr_ok = 1'b1;
		unique case (paddr)
			INSTR1_OFS: rdata_next[7:0] = instr1_reg;
			INSTR2_OFS: rdata_next[7:0] = instr2_reg;
			INSTR3_OFS: rdata_next[11:0] = instr3_reg;
			STATUS_OFS: begin
				rdata_next[POR_BIT] = por_flag_reg;
				rdata_next[0] = temp_warning_input;
				rdata_next[1] = low_battery_input;
				rdata_next[2] = high_battery_input;
				rdata_next[3] = legacy;
				rdata_next[6:4] = state_reg;
			end
			CHSTAT_OFS, CHSTAT_OFS + 8'h04, CHSTAT_OFS + 8'h08, CHSTAT_OFS + 8'h0c: begin
				rdata_next[7:0] = ch_stat[paddr[3:2]];
			end
			default: addr_ok = 1'b0;
		endcase
	end

	// No wait state: setup latches the answer, the first access cycle completes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= setup;
			pslverr <= setup && !addr_ok;
			if (setup) begin
				prdata <= pwrite ? 32'h0000_0000 : rdata_next;
			end
		end
	end
endmodule : apms_top
